// ===== inc/lpm_pkg.sv
// constants and types for the low-power mode controller
// assumes one 50 MHz system clock; all counts derive from it
package lpm_pkg;

	// one-hot power modes
	typedef enum logic [7:0] {
		MODE_RUN = 8'h01,
		MODE_SLEEP = 8'h02,
		MODE_LP_RUN = 8'h04,
		MODE_LP_SLEEP = 8'h08,
		MODE_STOP_RTC = 8'h10,
		MODE_STOP_NORTC = 8'h20,
		MODE_STBY_RTC = 8'h40,
		MODE_STBY_NORTC = 8'h80
	} mode_t;

	// voltage scaling range codes
	localparam logic [1:0] RANGE_1 = 2'h1;
	localparam logic [1:0] RANGE_2 = 2'h2;
	localparam logic [1:0] RANGE_3 = 2'h3;

	// frequency ceilings and wait-state thresholds in kHz
	localparam logic [15:0] RANGE1_MAX_KHZ = 16'h7d00; // 32000
	localparam logic [15:0] RANGE2_MAX_KHZ = 16'h3e80; // 16000
	localparam logic [15:0] RANGE3_MAX_KHZ = 16'h1068; // 4200
	localparam logic [15:0] LP_RUN_MAX_KHZ = 16'h0083; // 131
	localparam logic [15:0] R1_WS_KHZ = 16'h3e80; // 16000
	localparam logic [15:0] R2_WS_KHZ = 16'h1f40; // 8000

	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int STOP_WAKE_NS = 3500;
	localparam int STBY_EXIT_NS = 60000;
	localparam int FREQ_STEP_NS = 5000;
	// longest times round down, least time rounds up
	localparam int STOP_WAKE_CYC = STOP_WAKE_NS / CLK_PERIOD_NS;
	localparam int STBY_EXIT_CYC = STBY_EXIT_NS / CLK_PERIOD_NS;
	localparam int FREQ_STEP_CYC =
		(FREQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 12;
	localparam int STEP_RATIO = 4;

	// reset values
	localparam logic [15:0] FREQ_RST_KHZ = 16'h0000;

endpackage

// ===== core/lpm_ctrl.sv
// low-power mode controller: mode state, clock/regulator steering,
// wake qualification, flash wait states and frequency-step checking
// assumes wake sources and pins are asynchronous; core requests,
// range, frequency and oscillator enables come from clk_sys logic
`timescale 1ns/100ps

module lpm_ctrl (
	input wire logic clk_sys, // 50 MHz system clock
	input wire logic rstn, // async reset, active low
	input wire logic req_valid, // core mode request strobe
	input wire lpm_pkg::mode_t req_mode, // requested mode
	input wire logic periph_event, // peripheral irq/event
	input wire logic [1:0] range_sel, // voltage scaling range
	input wire logic [15:0] cpu_freq_khz, // programmed cpu clock
	input wire logic msi_sw_en, // software multi_speed_osc on
	input wire logic hsi_sw_en, // software fast_internal_osc on
	input wire logic hse_sw_en, // software fast_external_osc on
	input wire logic pll_sw_en, // software pll on
	input wire logic lsi_sw_en, // software slow_internal_osc on
	input wire logic lse_sw_en, // software slow_external_osc on
	input wire logic vref_on, // internal reference enabled
	input wire logic [15:0] gpio_line, // external_interrupt_line gpio
	input wire logic supply_level_detector, // detector output
	input wire logic comp1_evt, // comparator 1 event
	input wire logic comp2_evt, // comparator 2 event
	input wire logic usb_wake, // usb wake event
	input wire logic serial_wake, // serial wake event
	input wire logic i2c_wake, // i2c wake event
	input wire logic low_power_serial_wake, // wake event
	input wire logic low_power_timer_wake, // wake event
	input wire logic [4:0] rtc_evt, // alarm a/b, tamper, stamp, wakeup
	input wire logic [2:0] wake_pin, // wake pins, rising edge
	input wire logic external_reset_pin_n, // external reset, low
	input wire logic independent_watchdog_rst, // watchdog reset
	input wire logic hsi_wake_req, // peripheral asks for hsi in stop
	output lpm_pkg::mode_t mode_ff, // current power mode
	output logic cpu_clk_en_ff, // processor clock running
	output logic periph_clk_en_ff, // peripheral clocks running
	output logic pll_en_ff, // pll enable
	output logic msi_en_ff, // multi_speed_osc enable
	output logic msi_low_ff, // multi_speed_osc at low speed
	output logic hsi_en_ff, // fast_internal_osc enable
	output logic hse_en_ff, // fast_external_osc enable
	output logic lsi_en_ff, // slow_internal_osc enable
	output logic lse_en_ff, // slow_external_osc enable
	output logic reg_lp_ff, // regulator in low-power state
	output logic reg_off_ff, // regulator off
	output logic core_pwr_ff, // core domain powered
	output logic retain_ff, // ram and registers retained
	output logic core_rst_ff, // core reset pulse on standby exit
	output logic flash_ws_ff, // flash wait state count
	output logic freq_ok_ff, // frequency within range ceiling, or low-power run ceiling when msi low
	output logic step_err_ff // sticky frequency-step violation
);

	localparam int CNTW = lpm_pkg::CNT_W;
	localparam logic [CNTW-1:0] STOP_LOAD =
		CNTW'(lpm_pkg::STOP_WAKE_CYC - 2);
	localparam logic [CNTW-1:0] STBY_LOAD =
		CNTW'(lpm_pkg::STBY_EXIT_CYC - 2);
	localparam logic [CNTW-1:0] STEP_LOAD =
		CNTW'(lpm_pkg::FREQ_STEP_CYC);
	localparam int STOP_DLY = lpm_pkg::STOP_WAKE_CYC;
	localparam int STBY_DLY = lpm_pkg::STBY_EXIT_CYC;

	////////////////////////////////////////////////////////////////////
	// synchronisers for asynchronous inputs

	localparam int SW = 36;
	logic [SW-1:0] async_in;
	logic [SW-1:0] meta_ff;
	logic [SW-1:0] sync_ff;
	logic [2:0] pin_dly_ff;

	assign async_in = {gpio_line, supply_level_detector, comp1_evt,
		comp2_evt, usb_wake, serial_wake, i2c_wake, low_power_serial_wake,
		low_power_timer_wake, rtc_evt, wake_pin, ~external_reset_pin_n,
		independent_watchdog_rst, hsi_wake_req, vref_on};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	logic [15:0] gpio_s;
	logic pvd_s, c1_s, c2_s, usb_s, ser_s, i2c_s, lps_s, lpt_s;
	logic [4:0] rtc_s;
	logic [2:0] pin_s;
	logic xrst_s, wdg_s, hsi_req_s, vref_s;

	assign {gpio_s, pvd_s, c1_s, c2_s, usb_s, ser_s, i2c_s, lps_s, lpt_s,
		rtc_s, pin_s, xrst_s, wdg_s, hsi_req_s, vref_s} = sync_ff;

	// wake pins act on a rising edge of the synchronised level
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			pin_dly_ff <= '0;
		else
			pin_dly_ff <= pin_s;
	end

	////////////////////////////////////////////////////////////////////
	// wake qualification

	logic rtc_mode, rtc_any, pin_rise, comp_wake;
	logic stop_src, stby_src, sleep_src, any_wake;

	assign rtc_mode = (mode_ff == lpm_pkg::MODE_STOP_RTC) ||
		(mode_ff == lpm_pkg::MODE_STBY_RTC);
	assign rtc_any = |rtc_s;
	assign pin_rise = |(pin_s & ~pin_dly_ff);
	assign comp_wake = vref_s && (c1_s || c2_s);
	assign stop_src = |gpio_s || pvd_s || comp_wake || usb_s || ser_s ||
		i2c_s || lps_s || lpt_s || (rtc_mode && rtc_any);
	assign stby_src = xrst_s || pin_rise ||
		(rtc_mode && (wdg_s || rtc_any));
	assign sleep_src = periph_event || stop_src;

	always_comb begin
		case (mode_ff)
			lpm_pkg::MODE_SLEEP,
			lpm_pkg::MODE_LP_SLEEP: any_wake = sleep_src;
			lpm_pkg::MODE_STOP_RTC,
			lpm_pkg::MODE_STOP_NORTC: any_wake = stop_src;
			lpm_pkg::MODE_STBY_RTC,
			lpm_pkg::MODE_STBY_NORTC: any_wake = stby_src;
			default: any_wake = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// mode state machine

	lpm_pkg::mode_t nxt_mode;
	logic waking_ff, nxt_waking;
	logic [CNTW-1:0] cnt_ff, nxt_cnt;
	logic nxt_core_rst;
	logic req_legal;

	// a request must be one-hot and differ from the current mode;
	// from low-power run, plain sleep is not reachable directly
	always_comb begin
		req_legal = req_valid && $onehot(req_mode) && req_mode != mode_ff;
		if (mode_ff == lpm_pkg::MODE_LP_RUN &&
			req_mode == lpm_pkg::MODE_SLEEP)
			req_legal = 1'b0;
	end

	always_comb begin
		nxt_mode = mode_ff;
		nxt_waking = waking_ff;
		nxt_cnt = cnt_ff;
		nxt_core_rst = 1'b0;
		case (mode_ff)
			lpm_pkg::MODE_RUN,
			lpm_pkg::MODE_LP_RUN: begin
				if (req_legal)
					nxt_mode = req_mode;
			end
			lpm_pkg::MODE_SLEEP,
			lpm_pkg::MODE_LP_SLEEP: begin
				if (any_wake)
					nxt_mode = lpm_pkg::MODE_RUN;
			end
			lpm_pkg::MODE_STOP_RTC,
			lpm_pkg::MODE_STOP_NORTC,
			lpm_pkg::MODE_STBY_RTC,
			lpm_pkg::MODE_STBY_NORTC: begin
				if (waking_ff) begin
					if (cnt_ff == '0) begin
						nxt_mode = lpm_pkg::MODE_RUN;
						nxt_waking = 1'b0;
						nxt_core_rst = mode_ff[6] || mode_ff[7];
					end else begin
						nxt_cnt = cnt_ff - 1'b1;
					end
				end else if (any_wake) begin
					nxt_waking = 1'b1;
					nxt_cnt = (mode_ff[6] || mode_ff[7]) ? STBY_LOAD :
						STOP_LOAD;
				end
			end
			default: begin
				nxt_mode = lpm_pkg::MODE_RUN;
				nxt_waking = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_ff <= lpm_pkg::MODE_RUN;
			waking_ff <= 1'b0;
			cnt_ff <= '0;
			core_rst_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			waking_ff <= nxt_waking;
			cnt_ff <= nxt_cnt;
			core_rst_ff <= nxt_core_rst;
		end
	end

	////////////////////////////////////////////////////////////////////
	// clock, oscillator and regulator steering from the next mode,
	// so every output lines up with mode_ff

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cpu_clk_en_ff <= 1'b1;
			periph_clk_en_ff <= 1'b1;
			pll_en_ff <= 1'b0;
			msi_en_ff <= 1'b1;
			msi_low_ff <= 1'b0;
			hsi_en_ff <= 1'b0;
			hse_en_ff <= 1'b0;
			lsi_en_ff <= 1'b0;
			lse_en_ff <= 1'b0;
			reg_lp_ff <= 1'b0;
			reg_off_ff <= 1'b0;
			core_pwr_ff <= 1'b1;
			retain_ff <= 1'b1;
		end else begin
			cpu_clk_en_ff <= 1'b0;
			periph_clk_en_ff <= 1'b0;
			pll_en_ff <= 1'b0;
			msi_en_ff <= 1'b0;
			msi_low_ff <= 1'b0;
			hsi_en_ff <= 1'b0;
			hse_en_ff <= 1'b0;
			// slow oscillators follow software unless rtc is dropped
			lsi_en_ff <= lsi_sw_en;
			lse_en_ff <= lse_sw_en;
			reg_lp_ff <= 1'b0;
			reg_off_ff <= 1'b0;
			core_pwr_ff <= 1'b1;
			retain_ff <= 1'b1;
			case (nxt_mode)
				lpm_pkg::MODE_RUN,
				lpm_pkg::MODE_SLEEP: begin
					cpu_clk_en_ff <= (nxt_mode == lpm_pkg::MODE_RUN);
					periph_clk_en_ff <= 1'b1;
					pll_en_ff <= pll_sw_en;
					msi_en_ff <= msi_sw_en;
					hsi_en_ff <= hsi_sw_en;
					hse_en_ff <= hse_sw_en;
				end
				lpm_pkg::MODE_LP_RUN,
				lpm_pkg::MODE_LP_SLEEP: begin
					cpu_clk_en_ff <= (nxt_mode == lpm_pkg::MODE_LP_RUN);
					periph_clk_en_ff <= 1'b1;
					msi_en_ff <= 1'b1;
					msi_low_ff <= 1'b1;
					hse_en_ff <= hse_sw_en;
					reg_lp_ff <= 1'b1;
				end
				lpm_pkg::MODE_STOP_RTC,
				lpm_pkg::MODE_STOP_NORTC: begin
					// the msi restarts while the wake delay runs
					msi_en_ff <= nxt_waking;
					hsi_en_ff <= hsi_req_s;
					reg_lp_ff <= 1'b1;
					if (nxt_mode == lpm_pkg::MODE_STOP_NORTC) begin
						lsi_en_ff <= 1'b0;
						lse_en_ff <= 1'b0;
					end
				end
				lpm_pkg::MODE_STBY_RTC,
				lpm_pkg::MODE_STBY_NORTC: begin
					reg_off_ff <= 1'b1;
					core_pwr_ff <= 1'b0;
					retain_ff <= 1'b0;
					if (nxt_mode == lpm_pkg::MODE_STBY_NORTC) begin
						lsi_en_ff <= 1'b0;
						lse_en_ff <= 1'b0;
					end
				end
				default: begin
					cpu_clk_en_ff <= 1'b1;
					periph_clk_en_ff <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// range ceilings and flash wait states

	logic [15:0] ceil_khz;
	logic nxt_ws;

	always_comb begin
		case (range_sel)
			lpm_pkg::RANGE_1: ceil_khz = lpm_pkg::RANGE1_MAX_KHZ;
			lpm_pkg::RANGE_2: ceil_khz = lpm_pkg::RANGE2_MAX_KHZ;
			lpm_pkg::RANGE_3: ceil_khz = lpm_pkg::RANGE3_MAX_KHZ;
			default: ceil_khz = '0;
		endcase
		if (msi_low_ff && ceil_khz > lpm_pkg::LP_RUN_MAX_KHZ)
			ceil_khz = lpm_pkg::LP_RUN_MAX_KHZ;
	end

	always_comb begin
		case (range_sel)
			lpm_pkg::RANGE_1: nxt_ws = cpu_freq_khz > lpm_pkg::R1_WS_KHZ;
			lpm_pkg::RANGE_2: nxt_ws = cpu_freq_khz > lpm_pkg::R2_WS_KHZ;
			default: nxt_ws = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flash_ws_ff <= 1'b0;
			freq_ok_ff <= 1'b0;
		end else begin
			flash_ws_ff <= nxt_ws;
			freq_ok_ff <= cpu_freq_khz <= ceil_khz;
		end
	end

	////////////////////////////////////////////////////////////////////
	// frequency-step watch: software owns the stepping, this only
	// flags a step that is too large or too soon after the last one

	logic [15:0] last_khz_ff;
	logic [CNTW-1:0] step_cnt_ff;
	logic freq_chg, bad_ratio;

	assign freq_chg = cpu_freq_khz != last_khz_ff;
	assign bad_ratio = {2'h0, last_khz_ff} >=
		(18'(lpm_pkg::STEP_RATIO) * {2'h0, cpu_freq_khz});

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			last_khz_ff <= lpm_pkg::FREQ_RST_KHZ;
			step_cnt_ff <= '0;
			step_err_ff <= 1'b0;
		end else begin
			last_khz_ff <= cpu_freq_khz;
			if (freq_chg) begin
				step_cnt_ff <= STEP_LOAD;
				if (bad_ratio || step_cnt_ff != '0)
					step_err_ff <= 1'b1;
			end else if (step_cnt_ff != '0) begin
				step_cnt_ff <= step_cnt_ff - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// standby exit age: the exit is too long for a plain delay,
	// so a helper counter measures it from the qualified wake

	logic stby_trig;
	logic [CNTW-1:0] exit_age_ff;

	assign stby_trig = (mode_ff[6] || mode_ff[7]) && !waking_ff && stby_src;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			exit_age_ff <= '0;
		else if (stby_trig)
			exit_age_ff <= CNTW'(1);
		else if (exit_age_ff != '0 && mode_ff != lpm_pkg::MODE_RUN)
			exit_age_ff <= exit_age_ff + 1'b1;
		else
			exit_age_ff <= '0;
	end

	////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence stop_idle_wake;
		(mode_ff == lpm_pkg::MODE_STOP_RTC ||
		mode_ff == lpm_pkg::MODE_STOP_NORTC) && !waking_ff && stop_src;
	endsequence

	sequence stby_idle_wake;
		(mode_ff == lpm_pkg::MODE_STBY_RTC ||
		mode_ff == lpm_pkg::MODE_STBY_NORTC) && !waking_ff && stby_src;
	endsequence

	sleep_clocks_a: assert property (
		mode_ff == lpm_pkg::MODE_SLEEP |-> !cpu_clk_en_ff && periph_clk_en_ff)
		else $error("sleep clocks wrong");

	lprun_osc_a: assert property (
		mode_ff == lpm_pkg::MODE_LP_RUN |->
		msi_en_ff && msi_low_ff && reg_lp_ff && !pll_en_ff)
		else $error("low-power run clocking wrong");

	lpsleep_wake_a: assert property (
		mode_ff == lpm_pkg::MODE_LP_SLEEP && periph_event |=>
		mode_ff == lpm_pkg::MODE_RUN && !reg_lp_ff && cpu_clk_en_ff)
		else $error("low-power sleep wake wrong");

	stop_rtc_osc_a: assert property (
		mode_ff == lpm_pkg::MODE_STOP_RTC |-> !pll_en_ff && !hse_en_ff &&
		!cpu_clk_en_ff && retain_ff && lse_en_ff == $past(lse_sw_en))
		else $error("stop with rtc clocking wrong");

	stop_nortc_osc_a: assert property (
		mode_ff == lpm_pkg::MODE_STOP_NORTC |->
		!lsi_en_ff && !lse_en_ff && reg_lp_ff && retain_ff)
		else $error("stop without rtc clocking wrong");

	stop_wake_a: assert property (
		stop_idle_wake |-> ##STOP_DLY mode_ff == lpm_pkg::MODE_RUN)
		else $error("stop wake latency wrong");

	stby_start_a: assert property (
		stby_idle_wake |=> waking_ff)
		else $error("standby wake not started");

	stby_exit_a: assert property (
		exit_age_ff == CNTW'(STBY_DLY) |->
		mode_ff == lpm_pkg::MODE_RUN && core_rst_ff)
		else $error("standby exit latency wrong");

	stby_early_a: assert property (
		exit_age_ff != '0 && exit_age_ff != CNTW'(STBY_DLY) |->
		mode_ff != lpm_pkg::MODE_RUN)
		else $error("standby exit too early");

	stby_power_a: assert property (
		mode_ff[6] || mode_ff[7] |-> reg_off_ff && !core_pwr_ff && !retain_ff)
		else $error("standby power wrong");

	wait_state_a: assert property (
		range_sel == lpm_pkg::RANGE_3 |=> !flash_ws_ff)
		else $error("range 3 wait state wrong");

	mode_hold_a: assert property (
		!req_valid && !any_wake && !waking_ff |=> $stable(mode_ff))
		else $error("mode changed without cause");

endmodule // lpm_ctrl

// ===== test/lpm_core_model.sv
// partner model of the processor core: mode requests and cpu clock steps
// assumes the bench raises cmd_go for one cycle at a falling edge
`timescale 1ns/100ps

module lpm_core_model (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic cmd_go, // bench asks for one mode request
	input wire lpm_pkg::mode_t cmd_mode, // mode to request
	input wire logic [15:0] tgt_khz, // wanted cpu clock
	input wire logic jump, // step straight to target, even if unsafe
	output logic req_valid, // mode request strobe
	output lpm_pkg::mode_t req_mode, // requested mode
	output logic [15:0] cpu_freq_khz, // current cpu clock
	output logic busy // clock stepping still in progress
);
	int gap;
	int lo;

	assign lo = int'(cpu_freq_khz) / lpm_pkg::STEP_RATIO + 1;
	assign busy = (gap != 0) || (cpu_freq_khz !== tgt_khz);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			req_valid <= 1'b0;
			req_mode <= lpm_pkg::MODE_RUN;
		end else begin
			req_valid <= cmd_go;
			req_mode <= cmd_go ? cmd_mode : req_mode;
		end
	end

	// a falling step stays above a quarter of the old clock, then rests
	// longer than the step time; jump breaks both on purpose
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cpu_freq_khz <= 16'h0fa0;
			gap <= 0;
		end else if (gap != 0) begin
			gap <= gap - 1;
		end else if (cpu_freq_khz !== tgt_khz) begin
			if (jump || int'(tgt_khz) >= lo) begin
				cpu_freq_khz <= tgt_khz;
			end else begin
				cpu_freq_khz <= 16'(lo);
			end
			gap <= jump ? 0 : lpm_pkg::FREQ_STEP_CYC + 10;
		end
	end
endmodule // lpm_core_model

// ===== test/low_power_mode_controller_bench.sv
// self-checking bench for the low-power mode controller
// assumes lpm_ctrl and the core partner model; inputs move at negedge
`timescale 1ns/100ps

module low_power_mode_controller_bench;
	localparam int SW = lpm_pkg::STOP_WAKE_CYC;
	localparam int BX = lpm_pkg::STBY_EXIT_CYC;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic cmd_go = 1'b0;
	lpm_pkg::mode_t cmd_mode = lpm_pkg::MODE_RUN;
	logic [15:0] tgt_khz = 16'h0fa0;
	logic jump = 1'b0;
	logic periph_event = 1'b0;
	logic [1:0] range_sel = 2'h3;
	logic vref_on = 1'b0;
	logic hsi_wake_req = 1'b0;
	logic [5:0] sw_en = 6'h3f;
	// gpio 15:0, events 23:16, rtc 28:24, pins 31:29, wdg 32, ext rst 33
	logic [33:0] src = '0;
	logic req_valid, busy, cpu_clk_en_ff, periph_clk_en_ff, pll_en_ff;
	logic msi_en_ff, msi_low_ff, hsi_en_ff, hse_en_ff, lsi_en_ff, lse_en_ff;
	logic reg_lp_ff, reg_off_ff, core_pwr_ff, retain_ff, core_rst_ff;
	logic flash_ws_ff, freq_ok_ff, step_err_ff;
	logic [15:0] cpu_freq_khz;
	lpm_pkg::mode_t req_mode;
	lpm_pkg::mode_t mode_ff;
	int fail_count = 0;
	int cmp_count = 0;

	always #10 clk_sys = ~clk_sys;

	lpm_core_model core (.clk_sys(clk_sys), .rstn(rstn), .cmd_go(cmd_go),
		.cmd_mode(cmd_mode), .tgt_khz(tgt_khz), .jump(jump),
		.req_valid(req_valid), .req_mode(req_mode),
		.cpu_freq_khz(cpu_freq_khz), .busy(busy));

	lpm_ctrl uut (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
		.req_mode(req_mode), .periph_event(periph_event),
		.range_sel(range_sel), .cpu_freq_khz(cpu_freq_khz),
		.msi_sw_en(sw_en[5]), .hsi_sw_en(sw_en[4]), .hse_sw_en(sw_en[3]),
		.pll_sw_en(sw_en[2]), .lsi_sw_en(sw_en[1]), .lse_sw_en(sw_en[0]),
		.vref_on(vref_on), .gpio_line(src[15:0]), .comp1_evt(src[16]),
		.comp2_evt(src[17]), .supply_level_detector(src[18]),
		.usb_wake(src[19]), .serial_wake(src[20]), .i2c_wake(src[21]),
		.low_power_serial_wake(src[22]), .low_power_timer_wake(src[23]),
		.rtc_evt(src[28:24]), .wake_pin(src[31:29]),
		.independent_watchdog_rst(src[32]),
		.external_reset_pin_n(!src[33]), .hsi_wake_req(hsi_wake_req),
		.mode_ff(mode_ff), .cpu_clk_en_ff(cpu_clk_en_ff),
		.periph_clk_en_ff(periph_clk_en_ff), .pll_en_ff(pll_en_ff),
		.msi_en_ff(msi_en_ff), .msi_low_ff(msi_low_ff),
		.hsi_en_ff(hsi_en_ff), .hse_en_ff(hse_en_ff), .lsi_en_ff(lsi_en_ff),
		.lse_en_ff(lse_en_ff), .reg_lp_ff(reg_lp_ff), .reg_off_ff(reg_off_ff),
		.core_pwr_ff(core_pwr_ff), .retain_ff(retain_ff),
		.core_rst_ff(core_rst_ff), .flash_ws_ff(flash_ws_ff),
		.freq_ok_ff(freq_ok_ff), .step_err_ff(step_err_ff));

	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic hang(input string nm);
		fail_count++;
		$display("CHECK FAILED %s expected done seen timeout", nm);
		tally_and_finish();
	endtask

	task automatic req(input lpm_pkg::mode_t m);
		cmd_mode = m;
		cmd_go = 1'b1;
		@(negedge clk_sys);
		cmd_go = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask

	// wake sources drop after a few cycles: the wake must still finish
	task automatic wait_run(input int bound, output int n);
		n = 0;
		while (mode_ff !== lpm_pkg::MODE_RUN) begin
			@(negedge clk_sys);
			n++;
			if (n == 4)
				src = '0;
			if (n > bound)
				hang("wait for run");
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic sleep_check();
		req(lpm_pkg::mode_t'(8'h03));
		chk("bad code", 16'(lpm_pkg::MODE_RUN), 16'(mode_ff));
		req(lpm_pkg::MODE_SLEEP);
		chk("sleep clocks", 2'h1, {cpu_clk_en_ff, periph_clk_en_ff});
		req(lpm_pkg::MODE_STOP_RTC);
		chk("sleep holds", 16'(lpm_pkg::MODE_SLEEP), 16'(mode_ff));
		periph_event = 1'b1;
		@(negedge clk_sys);
		periph_event = 1'b0;
		@(negedge clk_sys);
		chk("sleep wake", 16'(lpm_pkg::MODE_RUN), 16'(mode_ff));
	endtask

	task automatic lp_check();
		req(lpm_pkg::MODE_LP_RUN);
		chk("lp run osc", 3'h7, {msi_en_ff, msi_low_ff, reg_lp_ff});
		chk("lp ceiling", 1'b0, freq_ok_ff);
		req(lpm_pkg::MODE_LP_SLEEP);
		chk("lp sleep", 2'h1, {cpu_clk_en_ff, reg_lp_ff});
		periph_event = 1'b1;
		@(negedge clk_sys);
		periph_event = 1'b0;
		@(negedge clk_sys);
		chk("lp wake", {lpm_pkg::MODE_RUN, 2'h0},
			{mode_ff, reg_lp_ff, msi_low_ff});
	endtask

	task automatic low_wake(input lpm_pkg::mode_t m, input int bad,
		input int good, input int lo, input int hi);
		logic rtc;
		logic sb;
		int n;
		rtc = m inside {lpm_pkg::MODE_STOP_RTC, lpm_pkg::MODE_STBY_RTC};
		sb = m inside {lpm_pkg::MODE_STBY_RTC, lpm_pkg::MODE_STBY_NORTC};
		req(m);
		chk("cpu clock", 1'b0, cpu_clk_en_ff);
		chk("fast clocks", 4'h0,
			{pll_en_ff, msi_en_ff, hse_en_ff, hsi_en_ff});
		chk("slow oscs", {2{rtc}}, {lsi_en_ff, lse_en_ff});
		chk("regulator", 1'b1, sb ? reg_off_ff : reg_lp_ff);
		chk("core kept", {2{!sb}}, {core_pwr_ff, retain_ff});
		if (!sb) begin
			hsi_wake_req = 1'b1;
			repeat (4) @(negedge clk_sys);
			chk("hsi request", 1'b1, hsi_en_ff);
			hsi_wake_req = 1'b0;
			repeat (4) @(negedge clk_sys);
		end
		if (bad >= 0) begin
			src[bad] = 1'b1;
			repeat (4) @(negedge clk_sys);
			src[bad] = 1'b0;
			repeat (hi + 20) @(negedge clk_sys);
			chk("refused wake", 16'(m), 16'(mode_ff));
		end
		src[good] = 1'b1;
		wait_run(hi + 20, n);
		chk("wake cycles", 1'b1, (n >= lo && n <= hi));
		chk("core reset", sb, core_rst_ff);
		repeat (2) @(negedge clk_sys);
		chk("run clocks", 2'h3, {cpu_clk_en_ff, periph_clk_en_ff});
	endtask

	task automatic freq_pt(input logic [1:0] r, input logic [15:0] khz,
		input logic ws, input logic ok);
		int n;
		range_sel = r;
		tgt_khz = khz;
		n = 0;
		@(negedge clk_sys);
		while (busy) begin
			@(negedge clk_sys);
			n++;
			if (n > 2000)
				hang("clock step");
		end
		repeat (2) @(negedge clk_sys);
		chk("freq ok", ok, freq_ok_ff);
		if (ok)
			chk("flash wait", ws, flash_ws_ff);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk_sys);
		chk("reset mode", 16'(lpm_pkg::MODE_RUN), 16'(mode_ff));
		chk("reset on", 5'h1f, {cpu_clk_en_ff, periph_clk_en_ff,
			msi_en_ff, core_pwr_ff, retain_ff});
		chk("reset off", 3'h0, {reg_lp_ff, reg_off_ff, step_err_ff});
		rstn = 1'b1;
		sw_en = 6'h15;
		repeat (4) @(negedge clk_sys);
		chk("osc follow", 6'h15, {msi_en_ff, hsi_en_ff, hse_en_ff,
			pll_en_ff, lsi_en_ff, lse_en_ff});
		sw_en = 6'h3f;
		repeat (4) @(negedge clk_sys);
		sleep_check();
		lp_check();
		low_wake(lpm_pkg::MODE_STOP_RTC, 16, 5, SW, SW + 7);
		for (int i = 24; i < 29; i++)
			low_wake(lpm_pkg::MODE_STOP_RTC, -1, i, SW, SW + 7);
		vref_on = 1'b1;
		for (int i = 16; i < 24; i++)
			low_wake(lpm_pkg::MODE_STOP_NORTC, (i == 16) ? 24 : -1, i,
				SW, SW + 7);
		low_wake(lpm_pkg::MODE_STBY_NORTC, 32, 29, BX, BX + 10);
		low_wake(lpm_pkg::MODE_STBY_NORTC, 24, 33, BX, BX + 10);
		for (int i = 24; i < 34; i++)
			low_wake(lpm_pkg::MODE_STBY_RTC, -1, i, BX, BX + 10);
		freq_pt(2'h2, 16'h0fa0, 1'b0, 1'b1);
		freq_pt(2'h2, 16'h2ee0, 1'b1, 1'b1);
		freq_pt(2'h1, 16'h2ee0, 1'b0, 1'b1);
		freq_pt(2'h1, 16'h4e20, 1'b1, 1'b1);
		freq_pt(2'h2, 16'h4e20, 1'b0, 1'b0);
		freq_pt(2'h3, 16'h1f40, 1'b0, 1'b0);
		freq_pt(2'h3, 16'h0fa0, 1'b0, 1'b1);
		chk("legal steps", 1'b0, step_err_ff);
		jump = 1'b1;
		freq_pt(2'h3, 16'h0320, 1'b0, 1'b1);
		chk("step too far", 1'b1, step_err_ff);
		tally_and_finish();
	end
endmodule // low_power_mode_controller_bench
